// file: verilog/mci_pkg.sv
// Constants, codes and types shared by both ends of the motion command interface
`default_nettype none
package mci_pkg;
	localparam int AXES = 4;
	localparam int CLK_NS = 10;
	localparam int CMD_ACCEPT_NS = 250;
	localparam int CMD_ACCEPT_CYC = CMD_ACCEPT_NS / CLK_NS;
	localparam int DIV_STEPS = 16;
	////////////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] C_RANGE = 8'h00;
	localparam logic [7:0] C_JERK = 8'h01;
	localparam logic [7:0] C_ACC = 8'h02;
	localparam logic [7:0] C_DEC = 8'h03;
	localparam logic [7:0] C_SV = 8'h04;
	localparam logic [7:0] C_SPD = 8'h05;
	localparam logic [7:0] C_PULSE = 8'h06;
	localparam logic [7:0] C_DP = 8'h07;
	localparam logic [7:0] C_CENTER = 8'h08;
	localparam logic [7:0] C_LP = 8'h09;
	localparam logic [7:0] C_EP = 8'h0A;
	localparam logic [7:0] C_CP = 8'h0B;
	localparam logic [7:0] C_CM = 8'h0C;
	localparam logic [7:0] C_AO = 8'h0D;
	localparam logic [7:0] C_DRATE = 8'h0E;
	localparam logic [7:0] C_NOP = 8'h0F;
	localparam logic [7:0] C_RD_LP = 8'h10;
	localparam logic [7:0] C_RD_EP = 8'h11;
	localparam logic [7:0] C_RD_CV = 8'h12;
	localparam logic [7:0] C_RD_CA = 8'h13;
	localparam logic [7:0] C_RD_SB = 8'h14;
	localparam logic [7:0] C_DRV_FP = 8'h20;
	localparam logic [7:0] C_DRV_CN = 8'h23;
	localparam logic [7:0] C_HOLD = 8'h24;
	localparam logic [7:0] C_RELEASE = 8'h25;
	localparam logic [7:0] C_DSTOP = 8'h26;
	localparam logic [7:0] C_SSTOP = 8'h27;
	localparam logic [7:0] C_IP_FIRST = 8'h30;
	localparam logic [7:0] C_BP_EN = 8'h36;
	localparam logic [7:0] C_BP_DIS = 8'h37;
	localparam logic [7:0] C_DEC_EN = 8'h3B;
	localparam logic [7:0] C_DEC_DIS = 8'h3C;
	localparam logic [7:0] C_IP_LAST = 8'h3D;
	localparam logic [7:0] C_EM = 8'h60;
	localparam logic [7:0] C_HV = 8'h61;
	localparam logic [7:0] C_SM = 8'h64;
	localparam logic [7:0] C_SYNC = 8'h65;
	////////////////////////////////////////////////////////////////////////////////
	// Ranges and scale factors
	localparam logic [31:0] RANGE_MIN = 32'h00003E80;
	localparam logic [31:0] RANGE_MAX = 32'h007A1200;
	localparam logic [15:0] SPEED_MAX = 16'h1F40;
	localparam logic [31:0] FINISH_NEG_LIM = 32'h80000001;
	localparam logic [31:0] MULT_NUM = 32'h007A1200;
	localparam logic [31:0] JERK_NUM = 32'h03B9ACA0;
	localparam logic [31:0] DEC_FACTOR = 32'h0000007D;
	localparam logic [15:0] AO_RESET = 16'h0000;
	// Validity bits of the drive-related parameters
	localparam int OK_R = 0;
	localparam int OK_K = 1;
	localparam int OK_A = 2;
	localparam int OK_D = 3;
	localparam int OK_SV = 4;
	localparam int OK_V = 5;
	localparam int OK_P = 6;
	localparam int OK_W = 7;
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [31:0] range;
		logic [15:0] jerk;
		logic [15:0] acc;
		logic [15:0] dec;
		logic [15:0] sv;
		logic [15:0] spd;
		logic [31:0] pulse;
		logic [31:0] dp;
		logic [31:0] center;
		logic [31:0] lp;
		logic [31:0] ep;
		logic [31:0] cp;
		logic [31:0] cm;
		logic [15:0] ao;
		logic [15:0] drate;
		logic [31:0] em;
		logic [15:0] hv;
		logic [31:0] sm;
	} mci_par_t;
	typedef struct packed {
		logic [31:0] start_pps;
		logic [31:0] drive_pps;
		logic [31:0] decel_pps;
		logic [47:0] jerk_pps;
	} mci_rate_t;
	typedef struct packed {
		logic [31:0] lp;
		logic [31:0] ep;
		logic [15:0] cv;
		logic [15:0] ca;
		logic [31:0] sb;
	} mci_stat_t;

	function automatic logic mci_is_param(input logic [7:0] c);
		return (c <= C_DRATE) || c == C_EM || c == C_HV || c == C_SM;
	endfunction : mci_is_param

	function automatic logic mci_is_len4(input logic [7:0] c);
		return c == C_RANGE || (c >= C_PULSE && c <= C_CM) || c == C_EM || c == C_SM;
	endfunction : mci_is_len4

	function automatic logic mci_is_defined(input logic [7:0] c);
		return mci_is_param(c) || (c >= C_NOP && c <= C_RD_SB)
			|| (c >= C_DRV_FP && c <= C_SSTOP) || (c >= C_IP_FIRST && c <= C_IP_LAST)
			|| (c >= C_HV && c <= C_SYNC);
	endfunction : mci_is_defined
endpackage : mci_pkg
`default_nettype wire

// file: verilog/mci_if.sv
// Parallel register link between the host end and the command interface
`default_nettype none
interface mci_if;
	logic        we_low;
	logic        we_high;
	logic [15:0] wdata;
	logic        cmd_we;
	logic [3:0]  axes;
	logic [7:0]  code;
	logic [15:0] rdata_low;
	logic [15:0] rdata_high;
	logic        busy;

	modport host (
		output we_low, we_high, wdata, cmd_we, axes, code,
		input  rdata_low, rdata_high, busy
	);
	modport dev (
		input  we_low, we_high, wdata, cmd_we, axes, code,
		output rdata_low, rdata_high, busy
	);
endinterface : mci_if
`default_nettype wire

// file: verilog/mci_dev.sv
// Device end: command decode, parameter store, data read, derived rates
//
// Contract
// - Read result: low half low, high half high
// - Codes 00-05 load range and speed parameters
// - Code 06 pulses/finish, 07 slowdown point
// - Codes 08-0C load signed four-byte values
// - Code 0D counter offset, 0E decel rate
// - Codes 60, 61, 64 load mode words
// - Host supplies full parameter length always
// - Codes 10-14 read positions, speed, buffer
// - Codes 20-23 start fixed or continuous drives
// - Hold, release, decelerating and immediate stop
// - Codes 30-35 select interpolation kind
// - Codes 36-3D bit pattern and step control
// - Home search, deviation clear, sync, nop
// - Host never writes undefined codes
// - Data words first, then command triggers
// - Same parameter to every selected axis
// - Out-of-range parameter blocks driving
// - Command accept time; host waits
// - Only counter offset defined after reset
// - Speeds scale by 8,000,000 over range
// - Deceleration is value times 125 times multiple
// - Jerk is 62.5e6 over value times multiple
`default_nettype none
module mci_dev
	import mci_pkg::*;
(
	input  wire logic                  clk_sys_i,
	input  wire logic                  arst_n_i,
	mci_if.dev                         bus,
	input  wire mci_pkg::mci_stat_t    stat_i [mci_pkg::AXES],
	output var  mci_pkg::mci_par_t     par_o [mci_pkg::AXES],
	output var  mci_pkg::mci_rate_t    rate_o [mci_pkg::AXES],
	output var  logic [mci_pkg::AXES-1:0] drv_ok_o,
	output var  logic                  ev_valid_o,
	output var  logic [7:0]            ev_code_o,
	output var  logic [mci_pkg::AXES-1:0] ev_axes_o,
	output var  logic [mci_pkg::AXES-1:0] hold_o,
	output var  logic                  bp_wr_en_o,
	output var  logic                  decel_en_o
);
	import mci_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		mci_par_t [AXES-1:0]    par;
		mci_rate_t [AXES-1:0]   rate;
		logic [AXES-1:0][OK_W-1:0] ok;
		logic [AXES-1:0][31:0]  mult;
		logic [AXES-1:0][31:0]  jbase;
		logic [15:0]            wlow;
		logic [15:0]            whigh;
		logic [15:0]            rlow;
		logic [15:0]            rhigh;
		logic [7:0]             cnt;
		logic                   div_run;
		logic                   div_jerk;
		logic [3:0]             div_cnt;
		logic [AXES-1:0]        div_axes;
		logic [31:0]            div_num;
		logic [31:0]            div_den;
		logic [32:0]            div_rem;
		logic [31:0]            div_quo;
		logic                   ev_valid;
		logic [7:0]             ev_code;
		logic [AXES-1:0]        ev_axes;
		logic [AXES-1:0]        hold;
		logic                   bp_wr_en;
		logic                   decel_en;
		logic [AXES-1:0]        drv_ok;
		logic                   busy;
	} mci_dev_st_t;

	mci_dev_st_t s_q;
	mci_dev_st_t s_d;

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic [31:0] v4;
		logic [15:0] v2;
		int rd_ax;
		v4 = {s_q.whigh, s_q.wlow};
		v2 = s_q.wlow;
		rd_ax = 0;
		s_d = s_q;
		s_d.ev_valid = 1'b0;
		if (s_q.cnt != 8'h00)
		begin
			s_d.cnt = s_q.cnt - 8'h01;
		end
		if (bus.we_low)
		begin
			s_d.wlow = bus.wdata;
		end
		if (bus.we_high)
		begin
			s_d.whigh = bus.wdata;
		end
		// Serial divider, two quotient bits per cycle, done inside the accept window
		if (s_q.div_run)
		begin
			for (int k = 0; k < 2; k++)
			begin
				s_d.div_rem = {s_d.div_rem[31:0], s_d.div_num[31]};
				s_d.div_num = {s_d.div_num[30:0], 1'b0};
				s_d.div_quo = {s_d.div_quo[30:0], 1'b0};
				if (s_d.div_rem >= {1'b0, s_d.div_den})
				begin
					s_d.div_rem = s_d.div_rem - {1'b0, s_d.div_den};
					s_d.div_quo[0] = 1'b1;
				end
			end
			s_d.div_cnt = s_q.div_cnt + 4'h1;
			if (s_q.div_cnt == 4'(DIV_STEPS - 1))
			begin
				s_d.div_run = 1'b0;
				for (int a = 0; a < AXES; a++)
				begin
					if (s_q.div_axes[a] && s_q.div_jerk)
					begin
						s_d.jbase[a] = s_d.div_quo;
					end
					else if (s_q.div_axes[a])
					begin
						s_d.mult[a] = s_d.div_quo;
					end
				end
			end
		end
		for (int a = AXES - 1; a >= 0; a--)
		begin
			if (bus.axes[a])
			begin
				rd_ax = a;
			end
		end
		// Command execution, ignored while the previous one is still being accepted
		if (bus.cmd_we && s_q.cnt == 8'h00)
		begin
			s_d.cnt = 8'(CMD_ACCEPT_CYC);
			s_d.ev_valid = 1'b1;
			s_d.ev_code = bus.code;
			s_d.ev_axes = bus.axes;
			if (bus.code >= C_DRV_FP && bus.code <= C_DRV_CN)
			begin
				s_d.ev_axes = bus.axes & s_q.drv_ok;
			end
			for (int a = 0; a < AXES; a++)
			begin
				if (bus.axes[a])
				begin
					case (bus.code)
						C_RANGE:
						begin
							s_d.par[a].range = v4;
							s_d.ok[a][OK_R] = v4 >= RANGE_MIN && v4 <= RANGE_MAX;
						end
						C_JERK:
						begin
							s_d.par[a].jerk = v2;
							s_d.ok[a][OK_K] = v2 != 16'h0000;
						end
						C_ACC:
						begin
							s_d.par[a].acc = v2;
							s_d.ok[a][OK_A] = v2 != 16'h0000 && v2 <= SPEED_MAX;
						end
						C_DEC:
						begin
							s_d.par[a].dec = v2;
							s_d.ok[a][OK_D] = v2 != 16'h0000 && v2 <= SPEED_MAX;
						end
						C_SV:
						begin
							s_d.par[a].sv = v2;
							s_d.ok[a][OK_SV] = v2 != 16'h0000 && v2 <= SPEED_MAX;
						end
						C_SPD:
						begin
							s_d.par[a].spd = v2;
							s_d.ok[a][OK_V] = v2 != 16'h0000 && v2 <= SPEED_MAX;
						end
						C_PULSE:
						begin
							s_d.par[a].pulse = v4;
							s_d.ok[a][OK_P] = v4 > FINISH_NEG_LIM || v4 < 32'h80000000;
						end
						C_DP: s_d.par[a].dp = v4;
						C_CENTER: s_d.par[a].center = v4;
						C_LP: s_d.par[a].lp = v4;
						C_EP: s_d.par[a].ep = v4;
						C_CP: s_d.par[a].cp = v4;
						C_CM: s_d.par[a].cm = v4;
						C_AO: s_d.par[a].ao = v2;
						C_DRATE: s_d.par[a].drate = v2;
						C_EM: s_d.par[a].em = v4;
						C_HV: s_d.par[a].hv = v2;
						C_SM: s_d.par[a].sm = v4;
						C_HOLD: s_d.hold[a] = 1'b1;
						C_RELEASE: s_d.hold[a] = 1'b0;
						default: ;
					endcase
				end
			end
			// Multiple and jerk base derive from the freshly written value
			if (bus.code == C_RANGE || bus.code == C_JERK)
			begin
				s_d.div_run = 1'b1;
				s_d.div_jerk = bus.code == C_JERK;
				s_d.div_cnt = 4'h0;
				s_d.div_axes = bus.axes;
				s_d.div_num = bus.code == C_JERK ? JERK_NUM : MULT_NUM;
				s_d.div_den = bus.code == C_JERK ? {16'h0000, v2} : v4;
				s_d.div_rem = '0;
				s_d.div_quo = '0;
			end
			case (bus.code)
				C_BP_EN: s_d.bp_wr_en = 1'b1;
				C_BP_DIS: s_d.bp_wr_en = 1'b0;
				C_DEC_EN: s_d.decel_en = 1'b1;
				C_DEC_DIS: s_d.decel_en = 1'b0;
				C_RD_LP: {s_d.rhigh, s_d.rlow} = stat_i[rd_ax].lp;
				C_RD_EP: {s_d.rhigh, s_d.rlow} = stat_i[rd_ax].ep;
				C_RD_CV: {s_d.rhigh, s_d.rlow} = {16'h0000, stat_i[rd_ax].cv};
				C_RD_CA: {s_d.rhigh, s_d.rlow} = {16'h0000, stat_i[rd_ax].ca};
				C_RD_SB: {s_d.rhigh, s_d.rlow} = stat_i[rd_ax].sb;
				default: ;
			endcase
		end
		// Rates follow the stored parameters every cycle
		for (int a = 0; a < AXES; a++)
		begin
			s_d.rate[a].start_pps = 32'(s_q.par[a].sv * s_q.mult[a]);
			s_d.rate[a].drive_pps = 32'(s_q.par[a].spd * s_q.mult[a]);
			s_d.rate[a].decel_pps = 32'(s_q.par[a].dec * DEC_FACTOR * s_q.mult[a]);
			s_d.rate[a].jerk_pps = 48'({16'h0000, s_q.jbase[a]} * s_q.mult[a]);
			s_d.drv_ok[a] = &s_d.ok[a];
		end
		s_d.busy = s_d.cnt != 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_q <= '0;
			for (int a = 0; a < AXES; a++)
			begin
				s_q.par[a].ao <= AO_RESET;
			end
		end
		else
		begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign bus.rdata_low = s_q.rlow;
	assign bus.rdata_high = s_q.rhigh;
	assign bus.busy = s_q.busy;
	assign ev_valid_o = s_q.ev_valid;
	assign ev_code_o = s_q.ev_code;
	assign ev_axes_o = s_q.ev_axes;
	assign hold_o = s_q.hold;
	assign bp_wr_en_o = s_q.bp_wr_en;
	assign decel_en_o = s_q.decel_en;
	assign drv_ok_o = s_q.drv_ok;

	for (genvar a = 0; a < AXES; a++)
	begin : g_out
		assign par_o[a] = s_q.par[a];
		assign rate_o[a] = s_q.rate[a];
	end
endmodule : mci_dev
`default_nettype wire

// file: verilog/mci_host.sv
// Host end: turns user requests into data, command and read sequences
`default_nettype none
module mci_host
	import mci_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	mci_if.host              bus,
	input  wire logic        req_valid_i,
	input  wire logic [7:0]  req_code_i,
	input  wire logic [3:0]  req_axes_i,
	input  wire logic [31:0] req_data_i,
	output var  logic        req_ready_o,
	output var  logic        req_err_o,
	output var  logic        rd_valid_o,
	output var  logic [31:0] rd_data_o
);
	import mci_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_HIGH = 3'h1,
		H_LOW  = 3'h3,
		H_CMD  = 3'h2,
		H_WAIT = 3'h6
	} mci_hst_t;

	typedef struct packed {
		mci_hst_t    st;
		logic [7:0]  code;
		logic [3:0]  axes;
		logic [15:0] lo;
		logic [15:0] wdata;
		logic        we_low;
		logic        we_high;
		logic        cmd_we;
		logic        ready;
		logic        err;
		logic        rd_valid;
		logic [31:0] rd_data;
	} mci_host_st_t;

	mci_host_st_t s_q;
	mci_host_st_t s_d;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		s_d = s_q;
		s_d.we_low = 1'b0;
		s_d.we_high = 1'b0;
		s_d.cmd_we = 1'b0;
		s_d.err = 1'b0;
		s_d.rd_valid = 1'b0;
		case (s_q.st)
			H_IDLE:
			begin
				if (req_valid_i && !mci_is_defined(req_code_i))
				begin
					s_d.err = 1'b1;
				end
				else if (req_valid_i)
				begin
					s_d.code = req_code_i;
					s_d.axes = req_axes_i;
					s_d.lo = req_data_i[15:0];
					if (mci_is_len4(req_code_i))
					begin
						s_d.st = H_HIGH;
						s_d.we_high = 1'b1;
						s_d.wdata = req_data_i[31:16];
					end
					else if (mci_is_param(req_code_i))
					begin
						s_d.st = H_LOW;
						s_d.we_low = 1'b1;
						s_d.wdata = req_data_i[15:0];
					end
					else
					begin
						s_d.st = H_CMD;
						s_d.cmd_we = 1'b1;
					end
				end
			end
			H_HIGH:
			begin
				s_d.st = H_LOW;
				s_d.we_low = 1'b1;
				s_d.wdata = s_q.lo;
			end
			H_LOW:
			begin
				s_d.st = H_CMD;
				s_d.cmd_we = 1'b1;
			end
			H_CMD:
			begin
				s_d.st = H_WAIT;
			end
			H_WAIT:
			begin
				if (!bus.busy)
				begin
					s_d.st = H_IDLE;
					s_d.rd_valid = s_q.code >= C_RD_LP && s_q.code <= C_RD_SB;
					s_d.rd_data = {bus.rdata_high, bus.rdata_low};
				end
			end
			default: s_d.st = H_IDLE;
		endcase
		s_d.ready = s_d.st == H_IDLE;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_q <= '0;
			s_q.ready <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign bus.we_low = s_q.we_low;
	assign bus.we_high = s_q.we_high;
	assign bus.wdata = s_q.wdata;
	assign bus.cmd_we = s_q.cmd_we;
	assign bus.axes = s_q.axes;
	assign bus.code = s_q.code;
	assign req_ready_o = s_q.ready;
	assign req_err_o = s_q.err;
	assign rd_valid_o = s_q.rd_valid;
	assign rd_data_o = s_q.rd_data;
endmodule : mci_host
`default_nettype wire

// file: testbench/mci_link_assertions.sv
// Protocol checker on the link between the host end and the device end
`default_nettype none
module mci_link_assertions
	import mci_pkg::*;
(
	input wire logic        clk_sys_i,
	input wire logic        arst_n_i,
	input wire logic        we_low,
	input wire logic        we_high,
	input wire logic [15:0] wdata,
	input wire logic        cmd_we,
	input wire logic [3:0]  axes,
	input wire logic [7:0]  code,
	input wire logic [15:0] rdata_low,
	input wire logic [15:0] rdata_high,
	input wire logic        busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] busy_cnt_q;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);
	////////////////////////////////////////////////////////////////////////////////
	// Length of the current busy run
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			busy_cnt_q <= 6'h00;
		else
			busy_cnt_q <= busy ? busy_cnt_q + 6'h01 : 6'h00;
	end
	sequence s_pair;
		we_high ##1 we_low;
	endsequence
	sequence s_cmd4;
		cmd_we && mci_is_len4(code);
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_busy_length: assert property ($fell(busy) |-> busy_cnt_q == 6'(CMD_ACCEPT_CYC))
		else $error("busy run has wrong length");
	a_busy_bound: assert property (busy |-> busy_cnt_q < 6'(CMD_ACCEPT_CYC))
		else $error("busy run too long");
	a_busy_cause: assert property ($rose(busy) |-> $past(cmd_we))
		else $error("busy rose without command");
	a_cmd_starts: assert property (cmd_we && !busy |=> busy)
		else $error("command not followed by busy");
	a_no_cmd_busy: assert property (busy |-> !cmd_we)
		else $error("command written while busy");
	a_pair_then_cmd: assert property (s_pair |=> s_cmd4)
		else $error("data pair not followed by command");
	a_cmd4_data: assert property (s_cmd4 |-> $past(we_low) && $past(we_high, 2))
		else $error("four-byte command without both words");
	a_cmd2_data: assert property (cmd_we && mci_is_param(code) && !mci_is_len4(code)
		|-> $past(we_low) && !$past(we_high))
		else $error("two-byte command without low word");
	a_code_defined: assert property (cmd_we |-> mci_is_defined(code))
		else $error("undefined code written");
	a_read_result: assert property ($changed(rdata_low) || $changed(rdata_high)
		|-> $rose(busy))
		else $error("read words changed outside a command");
endmodule : mci_link_assertions
`default_nettype wire

// file: testbench/mci_tb.sv
// Self-checking bench for the host and device ends joined by the link
`default_nettype none
module mci_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mci_pkg::*;
	logic        clk_sys_i;
	logic        arst_n_i;
	logic        req_valid_i;
	logic [7:0]  req_code_i;
	logic [3:0]  req_axes_i;
	logic [31:0] req_data_i;
	logic        req_ready_o;
	logic        req_err_o;
	logic        rd_valid_o;
	logic [31:0] rd_data_o;
	mci_stat_t   stat_i [AXES];
	mci_par_t    par_o [AXES];
	mci_par_t    par_b [AXES];
	mci_rate_t   rate_o [AXES];
	logic [3:0]  drv_ok_o;
	logic [3:0]  hold_o;
	logic [3:0]  ev_axes_o;
	logic        ev_valid_o;
	logic [7:0]  ev_code_o;
	logic        bp_wr_en_o;
	logic        decel_en_o;
	logic [7:0]  ev_code_q;
	logic [3:0]  ev_axes_q;
	logic [31:0] rd_q;
	logic        err_q = 1'b0;
	logic [31:0] mult;
	int          mismatches;
	int          total_checks;
	logic [7:0]  pc [18] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h60, 8'h61, 8'h64};
	logic [31:0] pd [18] = '{32'h00003E80, 32'h000003E8, 32'h00000064, 32'h000000C8,
		32'h0000000A, 32'h00001F40, 32'h0FFFFFFF, 32'hFFFFFFFF, 32'h80000002, 32'hFFFFFFF6,
		32'h7FFFFFFF, 32'h80000000, 32'h00000001, 32'h00008000, 32'h0000FFFF, 32'hA5A5A5A5,
		32'h00001F40, 32'h5A5A5A5A};
	logic [7:0]  cc [26] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h30,
		8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C,
		8'h3D, 8'h62, 8'h63, 8'h65, 8'h0F};
	////////////////////////////////////////////////////////////////////////////////
	mci_if u_mci_if ();
	mci_if u_mci_if_b ();
	mci_host u_mci_host (.clk_sys_i, .arst_n_i, .bus(u_mci_if.host), .req_valid_i,
		.req_code_i, .req_axes_i, .req_data_i, .req_ready_o, .req_err_o, .rd_valid_o,
		.rd_data_o);
	mci_dev u_mci_dev (.clk_sys_i, .arst_n_i, .bus(u_mci_if.dev), .stat_i, .par_o, .rate_o,
		.drv_ok_o, .ev_valid_o, .ev_code_o, .ev_axes_o, .hold_o, .bp_wr_en_o, .decel_en_o);
	mci_dev u_mci_dev_b (.clk_sys_i, .arst_n_i, .bus(u_mci_if_b.dev), .stat_i,
		.par_o(par_b), .rate_o(), .drv_ok_o(), .ev_valid_o(), .ev_code_o(), .ev_axes_o(),
		.hold_o(), .bp_wr_en_o(), .decel_en_o());
	mci_link_assertions u_chk (.clk_sys_i, .arst_n_i, .we_low(u_mci_if.we_low),
		.we_high(u_mci_if.we_high), .wdata(u_mci_if.wdata), .cmd_we(u_mci_if.cmd_we),
		.axes(u_mci_if.axes), .code(u_mci_if.code), .rdata_low(u_mci_if.rdata_low),
		.rdata_high(u_mci_if.rdata_high), .busy(u_mci_if.busy));
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys_i)
	begin
		if (ev_valid_o)
		begin
			ev_code_q <= ev_code_o;
			ev_axes_q <= ev_axes_o;
		end
		if (rd_valid_o)
			rd_q <= rd_data_o;
		if (req_err_o)
			err_q <= 1'b1;
	end
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	function automatic logic [31:0] par_field(input mci_par_t p, input logic [7:0] c);
		case (c)
			8'h00: return p.range;
			8'h01: return 32'(p.jerk);
			8'h02: return 32'(p.acc);
			8'h03: return 32'(p.dec);
			8'h04: return 32'(p.sv);
			8'h05: return 32'(p.spd);
			8'h06: return p.pulse;
			8'h07: return p.dp;
			8'h08: return p.center;
			8'h09: return p.lp;
			8'h0A: return p.ep;
			8'h0B: return p.cp;
			8'h0C: return p.cm;
			8'h0D: return 32'(p.ao);
			8'h0E: return 32'(p.drate);
			8'h60: return p.em;
			8'h61: return 32'(p.hv);
			default: return p.sm;
		endcase
	endfunction : par_field
	function automatic logic [31:0] stat_val(input mci_stat_t s, input logic [7:0] c);
		case (c)
			8'h10: return s.lp;
			8'h11: return s.ep;
			8'h12: return 32'(s.cv);
			8'h13: return 32'(s.ca);
			default: return s.sb;
		endcase
	endfunction : stat_val
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_bit(input logic got, input logic exp);
		chk(64'(got), 64'(exp));
	endtask : chk_bit
	// One user request, then wait for the host end to be ready again
	task automatic req(input logic [7:0] c, input logic [3:0] a, input logic [31:0] d);
		int n;
		req_valid_i = 1'b1;
		req_code_i = c;
		req_axes_i = a;
		req_data_i = d;
		@(posedge clk_sys_i);
		#1;
		req_valid_i = 1'b0;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		if (n == 100)
			mismatches++;
		@(posedge clk_sys_i);
		#1;
	endtask : req
	// Raw two-byte command on the second link, no wait for busy
	task automatic raw_cmd(input logic [7:0] c, input logic [15:0] d);
		u_mci_if_b.wdata = d;
		u_mci_if_b.we_low = 1'b1;
		@(posedge clk_sys_i);
		#1;
		u_mci_if_b.we_low = 1'b0;
		u_mci_if_b.code = c;
		u_mci_if_b.cmd_we = 1'b1;
		@(posedge clk_sys_i);
		#1;
		u_mci_if_b.cmd_we = 1'b0;
	endtask : raw_cmd
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20000) @(posedge clk_sys_i);
		mismatches++;
		tally_and_finish();
	end
	initial
	begin
		mismatches = 0;
		total_checks = 0;
		arst_n_i = 1'b0;
		{req_valid_i, req_code_i, req_axes_i, req_data_i} = '0;
		{u_mci_if_b.we_low, u_mci_if_b.we_high, u_mci_if_b.cmd_we} = 3'h0;
		u_mci_if_b.wdata = 16'h0000;
		u_mci_if_b.code = 8'h00;
		u_mci_if_b.axes = 4'h1;
		for (int a = 0; a < AXES; a++)
			stat_i[a] = '{32'hFFFFFFF0 + 32'(a), 32'h12345678 ^ 32'(a), 16'h1F40 - 16'(a),
				16'h0100 + 16'(a), 32'hFEDCBA98 + 32'(a)};
		repeat (12) @(posedge clk_sys_i);
		#1;
		arst_n_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		chk(64'(drv_ok_o), 64'h0);
		chk(64'(par_o[0].ao), 64'(AO_RESET));
		for (int i = 0; i < 18; i++)
		begin
			req(pc[i], 4'b0101, pd[i]);
			chk(64'(par_field(par_o[0], pc[i])), 64'(pd[i]));
			chk(64'(par_field(par_o[2], pc[i])), 64'(pd[i]));
			chk(64'(par_field(par_o[1], pc[i])), 64'h0);
		end
		mult = MULT_NUM / pd[0];
		chk(64'(rate_o[0].start_pps), 64'(pd[4] * mult));
		chk(64'(rate_o[2].drive_pps), 64'(pd[5] * mult));
		chk(64'(rate_o[0].decel_pps), 64'(pd[3] * DEC_FACTOR * mult));
		chk(64'(rate_o[0].jerk_pps), 64'((JERK_NUM / pd[1]) * mult));
		chk(64'(drv_ok_o), 64'h5);
		req(C_RANGE, 4'b0100, 32'h00003E7F);
		chk(64'(drv_ok_o), 64'h1);
		req(C_RANGE, 4'b0100, 32'h007A1201);
		chk(64'(drv_ok_o), 64'h1);
		for (int i = 0; i < 26; i++)
		begin
			req(cc[i], 4'b0101, 32'h0);
			chk(64'(ev_code_q), 64'(cc[i]));
			chk(64'(ev_axes_q), (cc[i] inside {[8'h20:8'h23]}) ? 64'h1 : 64'h5);
			if (cc[i] == C_HOLD || cc[i] == C_RELEASE)
				chk(64'(hold_o), (cc[i] == C_HOLD) ? 64'h5 : 64'h0);
			if (cc[i] == C_BP_EN || cc[i] == C_BP_DIS)
				chk_bit(bp_wr_en_o, cc[i] == C_BP_EN);
			if (cc[i] == C_DEC_EN || cc[i] == C_DEC_DIS)
				chk_bit(decel_en_o, cc[i] == C_DEC_EN);
		end
		req(C_PULSE, 4'b0001, FINISH_NEG_LIM);
		chk(64'(drv_ok_o), 64'h0);
		for (int j = 0; j < 2; j++)
			for (logic [7:0] c = 8'h10; c <= 8'h14; c++)
			begin
				req(c, j ? 4'b1100 : 4'b0001, 32'h0);
				chk(64'(rd_q), 64'(stat_val(stat_i[j * 2], c)));
				chk(64'(u_mci_if.rdata_low), 64'(stat_val(stat_i[j * 2], c) & 32'hFFFF));
				chk(64'(u_mci_if.rdata_high), 64'(stat_val(stat_i[j * 2], c) >> 16));
			end
		req(8'h40, 4'b0001, 32'h0);
		chk_bit(err_q, 1'b1);
		raw_cmd(C_SPD, 16'h0064);
		raw_cmd(C_SPD, 16'h00C8);
		repeat (30) @(posedge clk_sys_i);
		#1;
		chk(64'(par_b[0].spd), 64'h64);
		raw_cmd(C_SPD, 16'h00C8);
		repeat (30) @(posedge clk_sys_i);
		#1;
		chk(64'(par_b[0].spd), 64'hC8);
		arst_n_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1;
		arst_n_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		chk(64'(drv_ok_o), 64'h0);
		tally_and_finish();
	end
endmodule : mci_tb
`default_nettype wire
